// ---- rtl/rcsr_cfg.svh ----
`ifndef RCSR_CFG_SVH
`define RCSR_CFG_SVH

// ----------------------------------------------------------------
// register addresses on the multiplexed address/data bus
// ----------------------------------------------------------------
`define RCSR_OFS_RATE       8'h0A
`define RCSR_OFS_MODE       8'h0B
`define RCSR_OFS_FLAGS      8'h0C
`define RCSR_OFS_VALID      8'h0D

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
// rate_and_divider_control
`define RCSR_RATE_TAP       3:0
`define RCSR_RATE_BASE      6:4
`define RCSR_RATE_PEND      7
// mode_and_interrupt_enable
`define RCSR_MODE_SET       7
`define RCSR_MODE_PIE       6
`define RCSR_MODE_AIE       5
`define RCSR_MODE_UIE       4
`define RCSR_MODE_SQUARE_WAVE_ENABLE      3
`define RCSR_MODE_BIN       2
`define RCSR_MODE_H24       1
`define RCSR_MODE_DSE       0
// interrupt_flags
`define RCSR_FLG_ANY        7
`define RCSR_FLG_PER        6
`define RCSR_FLG_ALM        5
`define RCSR_FLG_UPD        4
// valid_ram_time_status
`define RCSR_VLD_BIT        7

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define RCSR_RATE_RST       7'h00
`define RCSR_BYTE_ZERO      8'h00
`define RCSR_BASE_4M        3'h0
`define RCSR_BASE_1M        3'h1
`define RCSR_BASE_32K       3'h2
`define RCSR_EXP_4M         5'h16
`define RCSR_EXP_1M         5'h14
`define RCSR_EXP_32K        5'h0F
`define RCSR_ALM_ANY        2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCSR_CLK_NS         20
`define RCSR_T_BUC_NS       244000
`define RCSR_T_UC_FAST_NS   248000
`define RCSR_T_UC_SLOW_NS   1984000

`endif

// ---- rtl/rcsr_pkg.sv ----
package rcsr_pkg;

	// update sequencer states, one-hot
	typedef enum logic [2:0] {
		RCSR_ST_IDLE = 3'b001,
		RCSR_ST_LEAD = 3'b010,
		RCSR_ST_RUN  = 3'b100
	} rcsr_upd_st_t;

endpackage

// ---- rtl/rcsr_alarm_cmp.sv ----
`timescale 1ns/1ps
`include "rcsr_cfg.svh"

// ----------------------------------------------------------------
// one alarm byte against one time byte
// ----------------------------------------------------------------
module rcsr_alarm_cmp #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] alm_byte,
	input  wire logic [W-1:0] time_byte,
	output logic              match
);
	import rcsr_pkg::*;

	// top two bits set means any value matches
	assign match = (alm_byte[W-1:W-2] == `RCSR_ALM_ANY) || (alm_byte == time_byte);

endmodule // rcsr_alarm_cmp

// ---- rtl/rcsr_top.sv ----
// Contract
// - flag low guarantees no update starts for at least 244 us.
// - update flag is read-only and untouched by reset pin.
// - writing update-inhibit to 1 stops updates, then clears update flag.
// - update lasts 248 us on fast bases, 1984 us on 32.768 kHz.
// - each update advances time chain and compares alarm bytes.
// - base-select bits pick time base or hold divider in reset.
// - first update starts half a second after divider release.
// - base-select and tap-select bits read/write, kept over reset.
// - tap-select picks one of 15 taps or none for wave and flag.
// - inhibit low gives one advance per second; high aborts; reset keeps it.
// - periodic flag sets regardless of enable; enable gates interrupt; reset clears enable.
// - alarm flag on full match, 11XXXXXX matches anything; reset clears enable.
// - update-done enable cleared by reset and by writing inhibit to 1.
// - wave enable drives tap square wave, else pin low; reset clears.
// - binary-format bit changed only by software writes.
// - hour-format bit selects 24-hour when 1, changed only by software.
// - summer-time enable steers spring and autumn jumps; reset keeps it.
// - any-interrupt flag is OR of gated flags; drives interrupt pin low.
// - reading flag register clears all flags; reset pin low clears too.
// - periodic flag sets on each falling edge of the selected tap.
// - update-done flag sets at the end of each update.
// - unused low bits of flag and valid registers read zero.
// - valid bit zero while power sense low; set only by reading it.
`timescale 1ns/1ps
`include "rcsr_cfg.svh"

module rcsr_top #(
	parameter int unsigned T_BUC_CYC     = (`RCSR_T_BUC_NS + `RCSR_CLK_NS - 1) / `RCSR_CLK_NS,
	parameter int unsigned T_UC_FAST_CYC = (`RCSR_T_UC_FAST_NS + `RCSR_CLK_NS - 1) / `RCSR_CLK_NS,
	parameter int unsigned T_UC_SLOW_CYC = (`RCSR_T_UC_SLOW_NS + `RCSR_CLK_NS - 1) / `RCSR_CLK_NS,
	parameter int          CNT_W         = 17,
	parameter int          DIV_W         = 22
) (
	input  wire logic       SYS_CLK,
	input  wire logic       NRST,
	input  wire logic       PWR_UP_NRST,
	input  wire logic       BUS_CE_N,
	input  wire logic       BUS_AS,
	input  wire logic       BUS_DS,
	input  wire logic       BUS_RW,
	input  wire logic [7:0] BUS_AD_IN,
	output logic      [7:0] BUS_AD_OUT,
	output logic            BUS_AD_OE,
	input  wire logic       OSC_TICK,
	input  wire logic       POWER_SENSE_IN,
	input  wire logic [7:0] TIME_SEC,
	input  wire logic [7:0] TIME_MIN,
	input  wire logic [7:0] TIME_HOUR,
	input  wire logic [7:0] ALM_SEC,
	input  wire logic [7:0] ALM_MIN,
	input  wire logic [7:0] ALM_HOUR,
	output logic            IRQ_N,
	output logic            SQUARE_WAVE_OUT,
	output logic            ADVANCE_PULSE,
	output logic            UPDATE_PENDING_FLAG,
	output logic            BINARY_FORMAT_SELECT,
	output logic            HOUR24_SELECT,
	output logic            SUMMER_TIME_ENABLE
);
	import rcsr_pkg::*;

	localparam logic [CNT_W-1:0] BUC_LAST  = CNT_W'(T_BUC_CYC - 1);
	localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(T_UC_FAST_CYC - 1);
	localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(T_UC_SLOW_CYC - 1);
	localparam logic [DIV_W-1:0] DIV_ONES  = {DIV_W{1'b1}};

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0]       addr_r;
	logic             ds_q_r;
	logic [7:0]       ad_out_r;
	logic             ad_oe_r;
	logic [6:0]       rate_r;
	logic             set_r, pie_r, aie_r, uie_r, square_wave_enable_r, bin_r, h24_r, dse_r;
	logic             pf_r, af_r, uf_r;
	logic             vrt_r;
	logic             irq_n_r;
	logic             sqw_r;
	logic             adv_r;
	logic             uip_r;
	rcsr_upd_st_t     state_r;
	logic [CNT_W-1:0] upd_cnt_r;
	logic [DIV_W-1:0] div_cnt_r;
	logic             div_run_q_r;
	logic             tap_q_r;

	logic             acc, rd, wr;
	logic             rd_flags, rd_valid, wr_rate, wr_mode, mapped;
	logic [7:0]       rd_val;
	logic [2:0]       base_sel;
	logic [3:0]       tap_sel;
	logic             div_run, div_release;
	logic [4:0]       base_exp;
	logic [DIV_W-1:0] div_mask, div_half;
	logic             sec_evt;
	logic [4:0]       tap_exp, tap_idx;
	logic             tap_on, tap_bit;
	logic             pf_evt, af_evt, uf_evt;
	logic             upd_done;
	logic [CNT_W-1:0] uc_last;
	logic             any_interrupt_flag;
	logic [2:0]       alm_hit;

	assign base_sel = rate_r[`RCSR_RATE_BASE];
	assign tap_sel  = rate_r[`RCSR_RATE_TAP];

	// ----------------------------------------------------------------
	// bus access decode
	// ----------------------------------------------------------------
	// one access per rising data strobe while selected
	assign acc      = BUS_DS && !ds_q_r && !BUS_CE_N;
	assign rd       = acc && BUS_RW;
	assign wr       = acc && !BUS_RW;
	assign rd_flags = rd && (addr_r == `RCSR_OFS_FLAGS);
	assign rd_valid = rd && (addr_r == `RCSR_OFS_VALID);
	assign wr_rate  = wr && (addr_r == `RCSR_OFS_RATE);
	assign wr_mode  = wr && (addr_r == `RCSR_OFS_MODE);

	// address latch on address strobe
	always_ff @(posedge SYS_CLK) begin
		if (!PWR_UP_NRST) begin
			addr_r <= `RCSR_BYTE_ZERO;
			ds_q_r <= 1'b0;
		end else begin
			if (BUS_AS)
				addr_r <= BUS_AD_IN;
			ds_q_r <= BUS_DS;
		end
	end

	// read data mux, unused bits read zero
	always_comb begin
		rd_val = `RCSR_BYTE_ZERO;
		mapped = 1'b1;
		if (addr_r == `RCSR_OFS_RATE) begin
			rd_val = {uip_r, rate_r};
		end else if (addr_r == `RCSR_OFS_MODE) begin
			rd_val = {set_r, pie_r, aie_r, uie_r, square_wave_enable_r, bin_r, h24_r, dse_r};
		end else if (addr_r == `RCSR_OFS_FLAGS) begin
			rd_val = {any_interrupt_flag, pf_r, af_r, uf_r, 4'h0};
		end else if (addr_r == `RCSR_OFS_VALID) begin
			rd_val = {vrt_r, 7'h00};
		end else begin
			mapped = 1'b0;
		end
	end

	// read answer, one cycle after the strobe edge
	always_ff @(posedge SYS_CLK) begin
		if (!NRST || !PWR_UP_NRST) begin
			ad_out_r <= `RCSR_BYTE_ZERO;
			ad_oe_r  <= 1'b0;
		end else begin
			ad_out_r <= rd ? rd_val : `RCSR_BYTE_ZERO;
			ad_oe_r  <= rd && mapped;
		end
	end

	// ----------------------------------------------------------------
	// rate_and_divider_control
	// ----------------------------------------------------------------
	// kept across the reset pin, update flag never written
	always_ff @(posedge SYS_CLK) begin
		if (!PWR_UP_NRST)
			rate_r <= `RCSR_RATE_RST;
		else if (wr_rate)
			rate_r <= BUS_AD_IN[6:0];
	end

	// ----------------------------------------------------------------
	// mode_and_interrupt_enable
	// ----------------------------------------------------------------
	// software-only bits, reset pin leaves them alone
	always_ff @(posedge SYS_CLK) begin
		if (!PWR_UP_NRST) begin
			set_r <= 1'b0;
			bin_r <= 1'b0;
			h24_r <= 1'b0;
			dse_r <= 1'b0;
		end else if (wr_mode) begin
			set_r <= BUS_AD_IN[`RCSR_MODE_SET];
			bin_r <= BUS_AD_IN[`RCSR_MODE_BIN];
			h24_r <= BUS_AD_IN[`RCSR_MODE_H24];
			dse_r <= BUS_AD_IN[`RCSR_MODE_DSE];
		end
	end

	// enables cleared by the reset pin
	always_ff @(posedge SYS_CLK) begin
		if (!NRST || !PWR_UP_NRST) begin
			pie_r  <= 1'b0;
			aie_r  <= 1'b0;
			uie_r  <= 1'b0;
			square_wave_enable_r <= 1'b0;
		end else if (wr_mode) begin
			pie_r  <= BUS_AD_IN[`RCSR_MODE_PIE];
			aie_r  <= BUS_AD_IN[`RCSR_MODE_AIE];
			uie_r  <= BUS_AD_IN[`RCSR_MODE_UIE] && !BUS_AD_IN[`RCSR_MODE_SET];
			square_wave_enable_r <= BUS_AD_IN[`RCSR_MODE_SQUARE_WAVE_ENABLE];
		end
	end

	// ----------------------------------------------------------------
	// divider chain
	// ----------------------------------------------------------------
	// only the three base codes run, any other holds the chain
	always_comb begin
		div_run  = 1'b1;
		base_exp = `RCSR_EXP_4M;
		case (base_sel)
			`RCSR_BASE_4M:  base_exp = `RCSR_EXP_4M;
			`RCSR_BASE_1M:  base_exp = `RCSR_EXP_1M;
			`RCSR_BASE_32K: base_exp = `RCSR_EXP_32K;
			default:        div_run  = 1'b0;
		endcase
	end

	assign div_mask    = ~(DIV_ONES << base_exp);
	assign div_half    = DIV_W'(1) << (base_exp - 5'h01);
	assign div_release = div_run && !div_run_q_r;
	assign sec_evt     = div_run && div_run_q_r && OSC_TICK && (div_cnt_r == div_mask);

	// count time-base ticks, preload half a second on release
	always_ff @(posedge SYS_CLK) begin
		if (!PWR_UP_NRST) begin
			div_cnt_r   <= '0;
			div_run_q_r <= 1'b0;
		end else begin
			div_run_q_r <= div_run;
			if (!div_run)
				div_cnt_r <= '0;
			else if (div_release)
				div_cnt_r <= div_half;
			else if (OSC_TICK)
				div_cnt_r <= (div_cnt_r == div_mask) ? '0 : div_cnt_r + DIV_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// tap selection, periodic flag source and square wave
	// ----------------------------------------------------------------
	// 32.768 kHz base uses slower first two taps
	always_comb begin
		tap_on = (tap_sel != 4'h0);
		if ((tap_sel <= 4'h2) && (base_sel == `RCSR_BASE_32K))
			tap_exp = 5'h09 - {1'b0, tap_sel};
		else
			tap_exp = 5'h10 - {1'b0, tap_sel};
		tap_idx = base_exp - tap_exp - 5'h01;
		tap_bit = tap_on && div_run && (tap_idx < 5'h16) && div_cnt_r[tap_idx];
	end

	// falling edge of the selected tap marks one period
	assign pf_evt = tap_q_r && !tap_bit;

	always_ff @(posedge SYS_CLK) begin
		if (!PWR_UP_NRST)
			tap_q_r <= 1'b0;
		else
			tap_q_r <= tap_bit;
	end

	// square wave held low unless enabled
	always_ff @(posedge SYS_CLK) begin
		if (!NRST || !PWR_UP_NRST)
			sqw_r <= 1'b0;
		else
			sqw_r <= square_wave_enable_r && tap_bit;
	end

	// ----------------------------------------------------------------
	// update sequencer
	// ----------------------------------------------------------------
	assign uc_last  = (base_sel == `RCSR_BASE_32K) ? SLOW_LAST : FAST_LAST;
	assign upd_done = (state_r == RCSR_ST_RUN) && (upd_cnt_r == uc_last) && !set_r && div_run;

	// pending flag rises a full lead time before the update; not on reset pin
	always_ff @(posedge SYS_CLK) begin
		if (!PWR_UP_NRST) begin
			state_r   <= RCSR_ST_IDLE;
			upd_cnt_r <= '0;
			uip_r     <= 1'b0;
		end else begin
			case (state_r)
				RCSR_ST_IDLE: begin
					upd_cnt_r <= '0;
					if (sec_evt && !set_r) begin
						state_r <= RCSR_ST_LEAD;
						uip_r   <= 1'b1;
					end
				end
				RCSR_ST_LEAD: begin
					if (set_r || !div_run) begin
						state_r <= RCSR_ST_IDLE;
						uip_r   <= 1'b0;
					end else if (upd_cnt_r == BUC_LAST) begin
						state_r   <= RCSR_ST_RUN;
						upd_cnt_r <= '0;
					end else begin
						upd_cnt_r <= upd_cnt_r + CNT_W'(1);
					end
				end
				RCSR_ST_RUN: begin
					if (set_r || !div_run || (upd_cnt_r == uc_last)) begin
						state_r <= RCSR_ST_IDLE;
						uip_r   <= 1'b0;
					end else begin
						upd_cnt_r <= upd_cnt_r + CNT_W'(1);
					end
				end
				default: begin
					state_r <= RCSR_ST_IDLE;
					uip_r   <= 1'b0;
				end
			endcase
		end
	end

	// advance strobe to the time chain
	always_ff @(posedge SYS_CLK) begin
		if (!NRST || !PWR_UP_NRST)
			adv_r <= 1'b0;
		else
			adv_r <= upd_done;
	end

	// ----------------------------------------------------------------
	// alarm compare
	// ----------------------------------------------------------------
	rcsr_alarm_cmp #(.W(8)) u_cmp_sec (
		.alm_byte  (ALM_SEC),
		.time_byte (TIME_SEC),
		.match     (alm_hit[0])
	);
	rcsr_alarm_cmp #(.W(8)) u_cmp_min (
		.alm_byte  (ALM_MIN),
		.time_byte (TIME_MIN),
		.match     (alm_hit[1])
	);
	rcsr_alarm_cmp #(.W(8)) u_cmp_hour (
		.alm_byte  (ALM_HOUR),
		.time_byte (TIME_HOUR),
		.match     (alm_hit[2])
	);

	assign af_evt = upd_done && (&alm_hit);
	assign uf_evt = upd_done;

	// ----------------------------------------------------------------
	// interrupt flags and request
	// ----------------------------------------------------------------
	// read clears, but a new event in that cycle wins
	always_ff @(posedge SYS_CLK) begin
		if (!NRST || !PWR_UP_NRST) begin
			pf_r <= 1'b0;
			af_r <= 1'b0;
			uf_r <= 1'b0;
		end else begin
			pf_r <= pf_evt || (pf_r && !rd_flags);
			af_r <= af_evt || (af_r && !rd_flags);
			uf_r <= uf_evt || (uf_r && !rd_flags);
		end
	end

	assign any_interrupt_flag = (pf_r && pie_r) || (af_r && aie_r) || (uf_r && uie_r);

	always_ff @(posedge SYS_CLK) begin
		if (!NRST || !PWR_UP_NRST)
			irq_n_r <= 1'b1;
		else
			irq_n_r <= !any_interrupt_flag;
	end

	// ----------------------------------------------------------------
	// valid_ram_time_status
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!PWR_UP_NRST)
			vrt_r <= 1'b0;
		else if (!POWER_SENSE_IN)
			vrt_r <= 1'b0;
		else if (rd_valid)
			vrt_r <= 1'b1;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign BUS_AD_OUT           = ad_out_r;
	assign BUS_AD_OE            = ad_oe_r;
	assign IRQ_N                = irq_n_r;
	assign SQUARE_WAVE_OUT      = sqw_r;
	assign ADVANCE_PULSE        = adv_r;
	assign UPDATE_PENDING_FLAG  = uip_r;
	assign BINARY_FORMAT_SELECT = bin_r;
	assign HOUR24_SELECT        = h24_r;
	assign SUMMER_TIME_ENABLE   = dse_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST || !PWR_UP_NRST);

	AST_LEAD_TIME: assert property (
		(state_r == RCSR_ST_RUN && $past(state_r) == RCSR_ST_LEAD) |-> $past(upd_cnt_r) == BUC_LAST && uip_r)
		else $error("update began before full lead time");
	AST_INHIBIT_CLR: assert property (
		(wr_mode && BUS_AD_IN[`RCSR_MODE_SET]) |-> ##2 !uip_r && state_r == RCSR_ST_IDLE)
		else $error("inhibit did not clear pending flag");
	AST_UIE_CLR: assert property (
		(wr_mode && BUS_AD_IN[`RCSR_MODE_SET]) |=> !uie_r)
		else $error("update-done enable survived inhibit write");
	AST_IRQ_PIN: assert property (
		any_interrupt_flag |=> !IRQ_N)
		else $error("interrupt pin not low while request set");
	AST_FLAG_KEEP: assert property (
		(rd_flags && pf_evt) |=> pf_r)
		else $error("periodic event lost at flag read");
	AST_FLAG_CLR: assert property (
		(rd_flags && !pf_evt && !af_evt && !uf_evt) |=> !pf_r && !af_r && !uf_r)
		else $error("flags not cleared by read");
	AST_WAVE_LOW: assert property (
		(!square_wave_enable_r ##1 !square_wave_enable_r) |-> !SQUARE_WAVE_OUT)
		else $error("square wave active while disabled");
	AST_VALID_LOW: assert property (
		!POWER_SENSE_IN |=> !vrt_r)
		else $error("valid bit set with power sense low");
	AST_HALF_SEC: assert property (
		div_release |=> div_cnt_r == $past(div_half))
		else $error("divider not preloaded to half second");
	AST_UF_END: assert property (
		upd_done |=> uf_r && ADVANCE_PULSE ##1 !ADVANCE_PULSE)
		else $error("update-done flag not set at update end");
	AST_RST_KEEP: assert property (
		@(posedge SYS_CLK) disable iff (!PWR_UP_NRST)
		(!NRST && !wr_rate && !wr_mode) |=> $stable(rate_r) && $stable(set_r) && $stable(bin_r) && $stable(dse_r))
		else $error("reset pin changed kept bits");

endmodule // rcsr_top

// ---- bench/rcsr_cpu_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// processor side of the multiplexed address/data bus
// ----------------------------------------------------------------
module rcsr_cpu_model (
	input  wire logic       clk,
	input  wire logic [7:0] ad_out,
	input  wire logic       ad_oe,
	output logic            ce_n,
	output logic            as_o,
	output logic            ds_o,
	output logic            rw_o,
	output logic      [7:0] ad_o
);
	// idle bus from time zero
	initial begin
		ce_n = 1'b1;
		as_o = 1'b0;
		ds_o = 1'b0;
		rw_o = 1'b1;
		ad_o = 8'h00;
	end

	// address phase, one data strobe, then wait up to two cycles for read data
	task automatic cyc(input logic rd, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		int k;
		@(negedge clk);
		ce_n = 1'b0;
		as_o = 1'b1;
		ad_o = a;
		@(negedge clk);
		as_o = 1'b0;
		ds_o = 1'b1;
		rw_o = rd;
		ad_o = rd ? ~a : d;   // a read leaves no stale address on the lines
		ok = 1'b0;
		q = 8'h00;
		for (k = 0; k < 2 && !ok; k++) begin
			@(negedge clk);
			ds_o = 1'b0;
			if (ad_oe === 1'b1) begin
				ok = 1'b1;
				q = ad_out;
			end
		end
		ce_n = 1'b1;
		rw_o = 1'b1;
		ad_o = ~ad_o;   // released lines change rather than hold the last byte
	endtask
endmodule // rcsr_cpu_model

// ---- bench/test_rtc_control_status_regs.sv ----
`timescale 1ns/1ps
`include "rcsr_cfg.svh"

// ----------------------------------------------------------------
// bench for the clock control and status registers
// ----------------------------------------------------------------
module test_rtc_control_status_regs;
	logic       sys_clk;
	logic       nrst;
	logic       pwr_nrst;
	logic       ps;
	logic       osc;
	logic [7:0] tm;
	logic [7:0] alm;
	logic       ce_n;
	logic       as_w;
	logic       ds_w;
	logic       rw_w;
	logic [7:0] ad_in;
	logic [7:0] ad_out;
	logic       ad_oe;
	logic       irq_n;
	logic       square_wave_out;
	logic       adv;
	logic       pend;
	logic       bin;
	logic       h24;
	logic       summer_time_enable;
	int         n_mismatch;
	int         checks_done;
	logic [7:0] rnd;
	logic [7:0] m_mode;
	logic [7:0] q;
	logic       ok;
	int         i;
	int         n;
	int         m;

	// device with shortened update timing
	rcsr_top #(.T_BUC_CYC(4), .T_UC_FAST_CYC(6), .T_UC_SLOW_CYC(10)) dut (
		.SYS_CLK(sys_clk), .NRST(nrst), .PWR_UP_NRST(pwr_nrst), .BUS_CE_N(ce_n), .BUS_AS(as_w),
		.BUS_DS(ds_w), .BUS_RW(rw_w), .BUS_AD_IN(ad_in), .BUS_AD_OUT(ad_out), .BUS_AD_OE(ad_oe),
		.OSC_TICK(osc), .POWER_SENSE_IN(ps), .TIME_SEC(tm), .TIME_MIN(tm), .TIME_HOUR(tm),
		.ALM_SEC(alm), .ALM_MIN(alm), .ALM_HOUR(alm), .IRQ_N(irq_n), .SQUARE_WAVE_OUT(square_wave_out),
		.ADVANCE_PULSE(adv), .UPDATE_PENDING_FLAG(pend), .BINARY_FORMAT_SELECT(bin),
		.HOUR24_SELECT(h24), .SUMMER_TIME_ENABLE(summer_time_enable));

	// processor model
	rcsr_cpu_model cpu (.clk(sys_clk), .ad_out(ad_out), .ad_oe(ad_oe), .ce_n(ce_n), .as_o(as_w),
		.ds_o(ds_w), .rw_o(rw_w), .ad_o(ad_in));

	// 50 MHz clock
	always #10 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic print_verdict;
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] qq;
		logic       kk;
		cpu.cyc(1'b0, a, d, qq, kk);
	endtask

	// read; a missing answer shows as unknown and never matches
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] qq;
		logic       kk;
		cpu.cyc(1'b1, a, 8'h00, qq, kk);
		chk(kk ? qq : 8'hXX, exp);
	endtask

	task automatic rd_only(input logic [7:0] a);
		logic [7:0] qq;
		logic       kk;
		cpu.cyc(1'b1, a, 8'h00, qq, kk);
	endtask

	// rising edges of the wave over 512 cycles after settling
	task automatic cnt_sqw(output int r);
		logic p;
		r = 0;
		repeat (256) @(negedge sys_clk);
		p = square_wave_out;
		repeat (512) begin
			@(negedge sys_clk);
			if (square_wave_out === 1'b1 && p === 1'b0)
				r++;
			p = square_wave_out;
		end
	endtask

	task automatic wait_pend(input int lim, output int c);
		c = 0;
		while (pend !== 1'b1) begin
			if (c >= lim) begin
				n_mismatch++;
				print_verdict;
			end
			@(negedge sys_clk);
			c++;
		end
	endtask

	// cycles with pending high and advance pulses over 40 cycles
	task automatic upd_len(output int c, output int a);
		c = 0;
		a = 0;
		repeat (40) begin
			if (pend === 1'b1)
				c++;
			if (adv === 1'b1)
				a++;
			@(negedge sys_clk);
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		pwr_nrst = 1'b0;
		ps = 1'b1;
		osc = 1'b1;
		tm = 8'h00;
		alm = 8'h00;
		n_mismatch = 0;
		checks_done = 0;
		rnd = 8'h47;
		repeat (12) @(negedge sys_clk);
		nrst = 1'b1;
		pwr_nrst = 1'b1;
		// status after power-up, unmapped read
		rdc(`RCSR_OFS_FLAGS, 8'h00);
		rd_only(`RCSR_OFS_VALID);
		rdc(`RCSR_OFS_VALID, 8'h80);
		cpu.cyc(1'b1, 8'h30, 8'h00, q, ok);
		chk({7'h00, ok}, 8'h00);
		// random register traffic against the model
		for (i = 0; i < 6; i++) begin
			rnd = nxt(rnd);
			// time bytes change only while no update is pending
			chk({7'h00, pend}, 8'h00);
			tm = rnd;
			wr(`RCSR_OFS_RATE, rnd);
			rdc(`RCSR_OFS_RATE, {1'b0, rnd[6:0]});
			rnd = nxt(rnd);
			alm = rnd;
			m_mode = rnd[7] ? (rnd & 8'hEF) : rnd;
			wr(`RCSR_OFS_MODE, rnd);
			rdc(`RCSR_OFS_MODE, m_mode);
			chk({5'h00, bin, h24, summer_time_enable}, {5'h00, m_mode[2:0]});
		end
		// pin reset clears enables only
		wr(`RCSR_OFS_RATE, 8'h26);
		wr(`RCSR_OFS_MODE, 8'hFF);
		nrst = 1'b0;
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		chk({7'h00, irq_n}, 8'h01);
		rdc(`RCSR_OFS_MODE, 8'h87);
		rdc(`RCSR_OFS_RATE, 8'h26);
		rdc(`RCSR_OFS_VALID, 8'h80);
		ps = 1'b0;
		rdc(`RCSR_OFS_VALID, 8'h00);
		ps = 1'b1;
		// square wave on each low tap of the 32.768 kHz base
		wr(`RCSR_OFS_MODE, 8'h88);
		for (i = 0; i < 8; i++) begin
			wr(`RCSR_OFS_RATE, 8'h20 | i[7:0]);
			cnt_sqw(n);
			m = (i == 0) ? 0 : (i < 3) ? (8 >> i) : (512 >> (i - 1));
			chk(n[7:0], m[7:0]);
		end
		// same tap on the two fast bases, 512 and 128 ticks a period
		wr(`RCSR_OFS_RATE, 8'h03);
		cnt_sqw(n);
		chk(n[7:0], 8'h01);
		wr(`RCSR_OFS_RATE, 8'h13);
		cnt_sqw(n);
		chk(n[7:0], 8'h04);
		wr(`RCSR_OFS_MODE, 8'h80);
		cnt_sqw(n);
		chk(n[7:0], 8'h00);
		// periodic flag with its enable off, then on
		wr(`RCSR_OFS_RATE, 8'h23);
		rd_only(`RCSR_OFS_FLAGS);
		repeat (10) @(negedge sys_clk);
		chk({7'h00, irq_n}, 8'h01);
		rdc(`RCSR_OFS_FLAGS, 8'h40);
		wr(`RCSR_OFS_MODE, 8'hC0);
		repeat (10) @(negedge sys_clk);
		chk({7'h00, irq_n}, 8'h00);
		rdc(`RCSR_OFS_FLAGS, 8'hC0);
		// first update half a second after divider release
		alm = 8'hC0;
		wr(`RCSR_OFS_RATE, 8'h60);
		wr(`RCSR_OFS_MODE, 8'h20);
		rd_only(`RCSR_OFS_FLAGS);
		wr(`RCSR_OFS_RATE, 8'h20);
		wait_pend(20000, n);
		chk({7'h00, n > 16376 && n < 16392}, 8'h01);
		upd_len(n, m);
		chk(n[7:0], 8'h0E);
		chk(m[7:0], 8'h01);
		chk({7'h00, irq_n}, 8'h00);
		rdc(`RCSR_OFS_FLAGS, 8'hB0);
		repeat (2) @(negedge sys_clk);
		chk({7'h00, irq_n}, 8'h01);
		// alarm bytes that differ from the time bytes raise no alarm
		alm = {2'h0, tm[5:0] ^ 6'h01};
		wr(`RCSR_OFS_RATE, 8'h60);
		wr(`RCSR_OFS_RATE, 8'h20);
		wait_pend(20000, n);
		upd_len(n, m);
		chk(m[7:0], 8'h01);
		rdc(`RCSR_OFS_FLAGS, 8'h10);
		// inhibit written while the next update is pending, in its lead time
		wait_pend(40000, n);
		wr(`RCSR_OFS_MODE, 8'hB0);
		chk({7'h00, pend}, 8'h00);
		upd_len(n, m);
		chk(n[7:0], 8'h00);
		chk(m[7:0], 8'h00);
		rdc(`RCSR_OFS_FLAGS, 8'h00);
		rdc(`RCSR_OFS_MODE, 8'hA0);
		print_verdict;
	end
endmodule // test_rtc_control_status_regs
